// File: rtl/prc_pkg.sv
package prc_pkg;

  // ****************************************
  // Register map and field layout
  // ****************************************
  localparam int         ADDR_W   = 6;
  localparam logic [5:0] OFF_DATA = 6'h00;
  localparam logic [5:0] OFF_ERR  = 6'h04;
  localparam logic [5:0] OFF_SCNT = 6'h08;
  localparam logic [5:0] OFF_SNUM = 6'h0c;
  localparam logic [5:0] OFF_CYLL = 6'h10;
  localparam logic [5:0] OFF_CYLH = 6'h14;
  localparam logic [5:0] OFF_DEVH = 6'h18;
  localparam logic [5:0] OFF_STAT = 6'h1c;
  localparam logic [5:0] OFF_MULT = 6'h20;
  localparam logic [5:0] OFF_CAPS = 6'h24;
  localparam logic [5:0] OFF_ECC  = 6'h28;

  localparam int ST_BSY      = 7;
  localparam int ST_DRDY     = 6;
  localparam int ST_DRQ      = 3;
  localparam int ST_CORR     = 2;
  localparam int ST_ERR      = 0;
  localparam int ER_UNC      = 6;
  localparam int ER_ABRT     = 2;
  localparam int CAP_LONG    = 0;
  localparam int CAP_MULT    = 1;
  localparam int MULT_EN_BIT = 8;

  // ****************************************
  // Opcodes, counts, reset values
  // ****************************************
  localparam logic [7:0] OP_SECT_R  = 8'h20;
  localparam logic [7:0] OP_SECT_NR = 8'h21;
  localparam logic [7:0] OP_LONG_R  = 8'h22;
  localparam logic [7:0] OP_LONG_NR = 8'h23;
  localparam logic [7:0] OP_MULT    = 8'hc4;

  localparam logic [8:0] MAX_SECT    = 9'h100;
  localparam logic [1:0] CAPS_RST    = 2'h3;
  localparam logic [7:0] ECC_RST     = 8'h04;
  localparam logic [7:0] MULT_RST    = 8'h00;
  localparam logic       MULT_EN_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [27:0] lba;
    logic [8:0]  nsect;
    logic        long_rd;
  } prc_media_req_t;

  typedef struct packed {
    logic unc;
    logic corr;
  } prc_media_stat_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_REQ  = 2'b01,
    S_WAIT = 2'b10,
    S_XFER = 2'b11
  } prc_state_t;

  function automatic logic [8:0] prc_min9(input logic [8:0] a, input logic [8:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic prc_mapped(input logic [5:0] a);
    return (a[1:0] == 2'h0) && (a <= OFF_ECC);
  endfunction

endpackage

// File: rtl/prc_axil.sv
`timescale 1ns/1ps
module prc_axil (
  input  wire logic        aclk,     // Clock
  input  wire logic        aresetn,  // Sync reset, low
  input  wire logic [5:0]  awaddr,   // Write address
  input  wire logic        awvalid,  // Write address valid
  output logic             awready,  // Write address ready
  input  wire logic [31:0] wdata,    // Write data
  input  wire logic [3:0]  wstrb,    // Byte enables
  input  wire logic        wvalid,   // Write data valid
  output logic             wready,   // Write data ready
  output logic [1:0]       bresp,    // Write response
  output logic             bvalid,   // Write response valid
  input  wire logic        bready,   // Write response ready
  input  wire logic [5:0]  araddr,   // Read address
  input  wire logic        arvalid,  // Read address valid
  output logic             arready,  // Read address ready
  output logic [31:0]      rdata,    // Read data
  output logic [1:0]       rresp,    // Read response
  output logic             rvalid,   // Read data valid
  input  wire logic        rready,   // Read data ready
  output logic             wr_en,    // Register write pulse
  output logic [5:0]       wr_addr,  // Register write address
  output logic [31:0]      wr_data,  // Register write data
  output logic [3:0]       wr_strb,  // Register write lanes
  output logic             rd_en,    // Register read pulse
  output logic [5:0]       rd_addr,  // Register read address
  input  wire logic [31:0] rd_data   // Register read value
);

  logic aw_held;
  logic w_held;
  logic next_aw_held;
  logic next_w_held;
  logic [5:0]  next_wr_addr;
  logic [31:0] next_wr_data;
  logic [3:0]  next_wr_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  assign awready = !aw_held;
  assign wready  = !w_held;
  assign arready = !rvalid;
  assign wr_en   = aw_held && w_held && !bvalid;
  assign rd_en   = arvalid && !rvalid;
  assign rd_addr = araddr;

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (awvalid && awready)
    begin
      next_aw_held = 1'b1;
      next_wr_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_w_held  = 1'b1;
      next_wr_data = wdata;
      next_wr_strb = wstrb;
    end
    if (wr_en)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = prc_pkg::prc_mapped(wr_addr) ? prc_pkg::RESP_OKAY : prc_pkg::RESP_SLVERR;
    end
    else if (bvalid && bready)
      next_bvalid = 1'b0;
    if (rd_en)
    begin
      next_rvalid = 1'b1;
      next_rdata  = rd_data;
      next_rresp  = prc_pkg::prc_mapped(araddr) ? prc_pkg::RESP_OKAY : prc_pkg::RESP_SLVERR;
    end
    else if (rvalid && rready)
      next_rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_addr <= 6'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= 2'h0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

endmodule

// File: rtl/prc_read_cmds.sv
// What this block does
// - Decode long read opcodes 22h (retries) and 23h (no retries).
// - Long read returns data plus check bytes and posts no data error.
// - Check bytes move one per transfer on the low eight data bits.
// - An unimplemented read command completes with an aborted-command error.
// - Unrecoverable error ends the command; address registers hold failing sector.
// - Starting address comes from address registers three to six.
// - Multiple read raises DRQ only at the start of each block.
// - Multiple read interrupts when DRQ sets per block, none between sectors.
// - Multiple read counts sectors; block size comes from stored block count.
// - Uneven count gives full blocks then one remainder block.
// - Multiple read aborts when no block count is set or reads disabled.
// - Block error posts at block start; whole block still transfers.
// - Only an unrecoverable error stops further blocks; a correctable error lets them follow.
// - Decode sector read opcodes 20h (retries) and 21h (no retries).
// - Sector read moves one to 256 sectors; zero count means 256.
// - Sector read sets DRQ before every transfer, error or not.
// - Retry and no-retry variants behave the same here.
// - Abort sets abort and error flags, clears busy, raises interrupt.
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module prc_read_cmds (
  input  wire logic                     aclk,            // Clock, 20 MHz
  input  wire logic                     aresetn,         // Sync reset, low
  input  wire logic [5:0]               s_axi_awaddr,    // Write address
  input  wire logic                     s_axi_awvalid,   // Write address valid
  output logic                          s_axi_awready,   // Write address ready
  input  wire logic [31:0]              s_axi_wdata,     // Write data
  input  wire logic [3:0]               s_axi_wstrb,     // Byte enables
  input  wire logic                     s_axi_wvalid,    // Write data valid
  output logic                          s_axi_wready,    // Write data ready
  output logic [1:0]                    s_axi_bresp,     // Write response
  output logic                          s_axi_bvalid,    // Write response valid
  input  wire logic                     s_axi_bready,    // Write response ready
  input  wire logic [5:0]               s_axi_araddr,    // Read address
  input  wire logic                     s_axi_arvalid,   // Read address valid
  output logic                          s_axi_arready,   // Read address ready
  output logic [31:0]                   s_axi_rdata,     // Read data
  output logic [1:0]                    s_axi_rresp,     // Read response
  output logic                          s_axi_rvalid,    // Read data valid
  input  wire logic                     s_axi_rready,    // Read data ready
  output logic                          intrq,           // Interrupt request, high
  output logic                          med_req_valid,   // Block fetch request
  output prc_pkg::prc_media_req_t       med_req,         // Block address and size
  input  wire logic                     med_ack,         // Block status pulse
  input  wire prc_pkg::prc_media_stat_t med_stat,        // Block error status
  input  wire logic                     med_data_valid,  // Media word valid
  input  wire logic [15:0]              med_data,        // Media word
  output logic                          med_data_ready   // Media word taken
);

  // ****************************************
  // Register bus
  // ****************************************
  logic        wr_en;
  logic [5:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        rd_en;
  logic [5:0]  rd_addr;
  logic [31:0] rd_data;

  prc_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // ****************************************
  // State
  // ****************************************
  prc_pkg::prc_state_t state, next_state;
  logic [7:0]  err_r,    next_err_r;
  logic [7:0]  scnt,     next_scnt;
  logic [7:0]  snum,     next_snum;
  logic [7:0]  cyll,     next_cyll;
  logic [7:0]  cylh,     next_cylh;
  logic [7:0]  devh,     next_devh;
  logic        bsy,      next_bsy;
  logic        drq,      next_drq;
  logic        err,      next_err;
  logic        corr,     next_corr;
  logic        irq,      next_irq;
  logic [7:0]  mult_cnt, next_mult_cnt;
  logic        mult_en,  next_mult_en;
  logic [1:0]  caps,     next_caps;
  logic [7:0]  ecc_len,  next_ecc_len;
  logic        cmd_long, next_cmd_long;
  logic        cmd_mult, next_cmd_mult;
  logic        unc_hit,  next_unc_hit;
  logic [8:0]  remain,   next_remain;
  logic [8:0]  blk,      next_blk;
  logic [16:0] words,    next_words;
  logic [7:0]  ecc_left, next_ecc_left;
  logic [15:0] data_q,   next_data_q;
  logic        data_v,   next_data_v;

  logic [27:0] lba;
  logic [27:0] lba_adv;
  logic [8:0]  nsect;
  logic [8:0]  remain_n;
  logic        cmd_wr;
  logic        blk_end;
  logic [7:0]  op;
  logic        is_sect;
  logic        is_long;
  logic        is_mult;
  logic        bad_cmd;

  assign lba      = {devh[3:0], cylh, cyll, snum};
  assign lba_adv  = lba + {19'h00000, blk};
  assign nsect    = cmd_mult ? prc_pkg::prc_min9(remain, {1'b0, mult_cnt}) : 9'h001;
  assign remain_n = remain - blk;
  assign op       = wr_data[7:0];
  assign cmd_wr   = wr_en && wr_strb[0] && (wr_addr == prc_pkg::OFF_STAT) && (state == prc_pkg::S_IDLE);
  assign is_sect  = (op == prc_pkg::OP_SECT_R) || (op == prc_pkg::OP_SECT_NR);
  assign is_long  = (op == prc_pkg::OP_LONG_R) || (op == prc_pkg::OP_LONG_NR);
  assign is_mult  = (op == prc_pkg::OP_MULT);
  assign bad_cmd  = (is_long && !caps[prc_pkg::CAP_LONG])
                 || (is_mult && (!caps[prc_pkg::CAP_MULT] || (mult_cnt == 8'h00) || !mult_en))
                 || !(is_sect || is_long || is_mult);
  assign blk_end  = (state == prc_pkg::S_XFER) && (words == 17'h00000) && (ecc_left == 8'h00) && !data_v;

  assign intrq          = irq;
  assign med_req_valid  = (state == prc_pkg::S_REQ);
  assign med_req        = '{lba: lba, nsect: nsect, long_rd: cmd_long};
  assign med_data_ready = (state != prc_pkg::S_IDLE) && (state != prc_pkg::S_REQ) && !data_v
                       && ((words != 17'h00000) || (ecc_left != 8'h00));

  // ****************************************
  // Register read mux
  // ****************************************
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      prc_pkg::OFF_DATA: rd_data = {16'h0000, data_q};
      prc_pkg::OFF_ERR:  rd_data = {24'h000000, err_r};
      prc_pkg::OFF_SCNT: rd_data = {24'h000000, scnt};
      prc_pkg::OFF_SNUM: rd_data = {24'h000000, snum};
      prc_pkg::OFF_CYLL: rd_data = {24'h000000, cyll};
      prc_pkg::OFF_CYLH: rd_data = {24'h000000, cylh};
      prc_pkg::OFF_DEVH: rd_data = {24'h000000, devh};
      prc_pkg::OFF_STAT: rd_data = {24'h000000, bsy, !bsy, 2'h0, drq, corr, 1'b0, err};
      prc_pkg::OFF_MULT: rd_data = {23'h000000, mult_en, mult_cnt};
      prc_pkg::OFF_CAPS: rd_data = {30'h00000000, caps};
      prc_pkg::OFF_ECC:  rd_data = {24'h000000, ecc_len};
      default:           rd_data = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Command engine
  // ****************************************
  always_comb
  begin
    next_state = state;    next_err_r = err_r;     next_scnt = scnt;
    next_snum = snum;      next_cyll = cyll;       next_cylh = cylh;
    next_devh = devh;      next_bsy = bsy;         next_drq = drq;
    next_err = err;        next_corr = corr;       next_irq = irq;
    next_mult_cnt = mult_cnt;  next_mult_en = mult_en;
    next_caps = caps;      next_ecc_len = ecc_len; next_cmd_long = cmd_long;
    next_cmd_mult = cmd_mult;  next_unc_hit = unc_hit;
    next_remain = remain;  next_blk = blk;         next_words = words;
    next_ecc_left = ecc_left;  next_data_q = data_q;   next_data_v = data_v;

    // Status read acknowledges the interrupt
    if (rd_en && (rd_addr == prc_pkg::OFF_STAT))
      next_irq = 1'b0;
    if (rd_en && (rd_addr == prc_pkg::OFF_DATA))
      next_data_v = 1'b0;

    if (wr_en && wr_strb[0] && (state == prc_pkg::S_IDLE))
    begin
      case (wr_addr)
        prc_pkg::OFF_SCNT: next_scnt = wr_data[7:0];
        prc_pkg::OFF_SNUM: next_snum = wr_data[7:0];
        prc_pkg::OFF_CYLL: next_cyll = wr_data[7:0];
        prc_pkg::OFF_CYLH: next_cylh = wr_data[7:0];
        prc_pkg::OFF_DEVH: next_devh = wr_data[7:0];
        prc_pkg::OFF_MULT: next_mult_cnt = wr_data[7:0];
        prc_pkg::OFF_CAPS: next_caps = wr_data[1:0];
        prc_pkg::OFF_ECC:  next_ecc_len = wr_data[7:0];
        default:           next_scnt = scnt;
      endcase
    end
    if (wr_en && wr_strb[1] && (wr_addr == prc_pkg::OFF_MULT) && (state == prc_pkg::S_IDLE))
      next_mult_en = wr_data[prc_pkg::MULT_EN_BIT];

    // Word and check-byte loading
    if (med_data_ready && med_data_valid)
    begin
      next_data_v = 1'b1;
      if (words != 17'h00000)
      begin
        next_data_q = med_data;
        next_words  = words - 17'h00001;
      end
      else
      begin
        next_data_q   = {8'h00, med_data[7:0]};
        next_ecc_left = ecc_left - 8'h01;
      end
    end

    case (state)
      prc_pkg::S_IDLE:
      begin
        if (cmd_wr)
        begin
          next_err_r = 8'h00;
          next_corr  = 1'b0;
          if (bad_cmd)
          begin
            next_err_r[prc_pkg::ER_ABRT] = 1'b1;
            next_err = 1'b1;
            next_bsy = 1'b0;
            next_irq = 1'b1;
          end
          else
          begin
            next_err      = 1'b0;
            next_bsy      = 1'b1;
            next_irq      = 1'b0;
            next_cmd_long = is_long;
            next_cmd_mult = is_mult;
            next_remain   = is_long ? 9'h001 : ((scnt == 8'h00) ? prc_pkg::MAX_SECT : {1'b0, scnt});
            next_state    = prc_pkg::S_REQ;
          end
        end
      end
      prc_pkg::S_REQ:
      begin
        if (med_ack)
        begin
          next_blk      = nsect;
          next_words    = {nsect, 8'h00};
          next_ecc_left = cmd_long ? ecc_len : 8'h00;
          next_unc_hit  = med_stat.unc && !cmd_long;
          if (!cmd_long && med_stat.unc)
          begin
            next_err = 1'b1;
            next_err_r[prc_pkg::ER_UNC] = 1'b1;
          end
          if (!cmd_long && med_stat.corr)
            next_corr = 1'b1;
          next_state = prc_pkg::S_WAIT;
        end
      end
      prc_pkg::S_WAIT:
      begin
        if (data_v)
        begin
          next_bsy   = 1'b0;
          next_drq   = 1'b1;
          next_irq   = 1'b1;
          next_state = prc_pkg::S_XFER;
        end
      end
      prc_pkg::S_XFER:
      begin
        if (blk_end)
        begin
          next_drq = 1'b0;
          if (unc_hit)
          begin
            next_bsy   = 1'b0;
            next_state = prc_pkg::S_IDLE;
          end
          else
          begin
            {next_devh[3:0], next_cylh, next_cyll, next_snum} = lba_adv;
            next_scnt   = remain_n[7:0];
            next_remain = remain_n;
            next_bsy    = (remain_n != 9'h000);
            next_state  = (remain_n != 9'h000) ? prc_pkg::S_REQ : prc_pkg::S_IDLE;
          end
        end
      end
      default: next_state = prc_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= prc_pkg::S_IDLE;  err_r <= 8'h00;  scnt <= 8'h00;
      snum <= 8'h00;  cyll <= 8'h00;  cylh <= 8'h00;  devh <= 8'h00;
      bsy <= 1'b0;  drq <= 1'b0;  err <= 1'b0;  corr <= 1'b0;  irq <= 1'b0;
      mult_cnt <= prc_pkg::MULT_RST;
      mult_en <= prc_pkg::MULT_EN_RST;
      caps <= prc_pkg::CAPS_RST;  ecc_len <= prc_pkg::ECC_RST;
      cmd_long <= 1'b0;  cmd_mult <= 1'b0;  unc_hit <= 1'b0;
      remain <= 9'h000;  blk <= 9'h000;  words <= 17'h00000;
      ecc_left <= 8'h00;  data_q <= 16'h0000;  data_v <= 1'b0;
    end
    else
    begin
      state <= next_state;  err_r <= next_err_r;  scnt <= next_scnt;
      snum <= next_snum;  cyll <= next_cyll;  cylh <= next_cylh;  devh <= next_devh;
      bsy <= next_bsy;  drq <= next_drq;  err <= next_err;  corr <= next_corr;  irq <= next_irq;
      mult_cnt <= next_mult_cnt;  mult_en <= next_mult_en;
      caps <= next_caps;  ecc_len <= next_ecc_len;
      cmd_long <= next_cmd_long;  cmd_mult <= next_cmd_mult;  unc_hit <= next_unc_hit;
      remain <= next_remain;  blk <= next_blk;  words <= next_words;
      ecc_left <= next_ecc_left;  data_q <= next_data_q;  data_v <= next_data_v;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_abort_flags:
  assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_wr && bad_cmd |=> err_r[prc_pkg::ER_ABRT] && err && !bsy && intrq && state == prc_pkg::S_IDLE)
  else $error("abort did not post flags");

  a_mult_reject:
  assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_wr && is_mult && (mult_cnt == 8'h00) |=> err_r[prc_pkg::ER_ABRT] && !med_req_valid)
  else $error("multiple read ran without block count");

  a_drq_irq_pair:
  assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(drq) |-> intrq && !bsy && data_v)
  else $error("DRQ rose without interrupt");

  a_drq_block_start:
  assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(drq) |-> $past(state) == prc_pkg::S_WAIT)
  else $error("DRQ rose inside a block");

  a_block_size:
  assert property (@(posedge aclk) disable iff (!aresetn)
    med_req_valid && cmd_mult |-> (med_req.nsect <= remain) && (med_req.nsect <= {1'b0, mult_cnt})
      && ((med_req.nsect == remain) || (med_req.nsect == {1'b0, mult_cnt})))
  else $error("block size wrong");

  a_zero_count:
  assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_wr && !bad_cmd && is_sect && (scnt == 8'h00) |=> remain == 9'h100 ##1 med_req.nsect == 9'h001)
  else $error("zero count not taken as 256");

  a_check_byte_lane:
  assert property (@(posedge aclk) disable iff (!aresetn)
    med_data_ready && med_data_valid && (words == 17'h00000) |=> data_v && data_q[15:8] == 8'h00)
  else $error("check byte on upper lane");

  a_long_no_error:
  assert property (@(posedge aclk) disable iff (!aresetn)
    med_ack && med_req_valid && cmd_long |=> !err && !corr && !unc_hit)
  else $error("long read posted data error");

  a_unc_stop:
  assert property (@(posedge aclk) disable iff (!aresetn)
    blk_end && unc_hit |=> state == prc_pkg::S_IDLE && !bsy && lba == $past(lba))
  else $error("unrecoverable error did not stop at failing sector");

endmodule

// File: verif/prc_media_model.sv
`timescale 1ns/1ps
module prc_media_model (
  input  wire logic                     aclk,      // Clock
  input  wire logic                     unc,       // Report unrecoverable
  input  wire logic                     corr,      // Report correctable
  input  wire logic                     req_valid, // Block request
  input  wire prc_pkg::prc_media_req_t  req,       // Block address and size
  output logic                          ack,       // Status pulse
  output prc_pkg::prc_media_stat_t      stat,      // Block status
  output logic                          dv,        // Word valid
  output logic [15:0]                   dw,        // Word
  input  wire logic                     dr,        // Word taken
  output logic [27:0]                   lba        // Last address asked
);
  logic [15:0] k;
  int          left;
  // Idle bus shows inverse so stale data never matches
  assign dw = dv ? k : ~k;
  initial
  begin
    {ack, stat, dv, k, left, lba} = '0;
  end
  always @(posedge aclk)
  begin
    ack <= 0;
    if (req_valid && !ack && left == 0 && !dv)
    begin
      ack <= 1;
      stat <= {unc, corr};
      lba <= req.lba;
      left <= req.nsect * 256 + (req.long_rd ? 4 : 0);
    end
    if (dv && dr)
    begin
      k <= k + 1;
      left <= left - 1;
    end
    dv <= left > ((dv && dr) ? 1 : 0);
  end
endmodule

// File: verif/pio_sector_read_commands_tb_top.sv
`timescale 1ns/1ps
module pio_sector_read_commands_tb_top;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, intrq, unc, cr;
  logic        arvalid, arready, rvalid, rready, mrv, mack, mdv, mdr;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, d;
  logic [31:0] rdata;
  logic [15:0] ek, mdw;
  logic [27:0] mlba;
  int          n_fail, checks;
  prc_pkg::prc_media_req_t  mreq;
  prc_pkg::prc_media_stat_t mst;
  localparam logic [5:0] ST = prc_pkg::OFF_STAT;
  localparam logic [5:0] SC = prc_pkg::OFF_SCNT;
  localparam logic [5:0] SN = prc_pkg::OFF_SNUM;
  prc_read_cmds u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .intrq(intrq), .med_req_valid(mrv),
    .med_req(mreq), .med_ack(mack), .med_stat(mst), .med_data_valid(mdv), .med_data(mdw), .med_data_ready(mdr));
  prc_media_model u_med (.aclk(aclk), .unc(unc), .req_valid(mrv), .req(mreq), .ack(mack), .stat(mst),
    .corr(cr), .dv(mdv), .dw(mdw), .dr(mdr), .lba(mlba));
  initial
  begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task summarize;
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task wr(input logic [5:0] a, input logic [31:0] v);
    logic ad, dd;
    {ad, dd} = 2'b00;
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
    do
    begin
      @(posedge aclk);
      ad |= awready;
      dd |= wready;
      if (ad) awvalid <= 0;
      if (dd) wvalid <= 0;
    end
    while (!(ad && dd));
    while (bvalid !== 1'b1) @(posedge aclk);
  endtask
  task rd(input logic [5:0] a);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
  endtask
  // Waits for the block interrupt, then pops every word and check byte
  task blk(input int n, input logic lng, input logic [7:0] st);
    for (int i = 0; i < 400 && intrq !== 1'b1; i++) @(posedge aclk);
    chk(intrq, 1);
    rd(ST);
    chk(d, st);
    for (int i = 0; i < n * 256 + (lng ? 4 : 0); i++)
    begin
      rd(prc_pkg::OFF_DATA);
      chk(d, i < n * 256 ? {16'h0, ek} : {24'h0, ek[7:0]});
      ek++;
      if (i == 256) chk(intrq, 0);
    end
  endtask
  initial
  begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    summarize();
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, unc, cr, awaddr, araddr, wdata, ek} = '0;
    {n_fail, checks} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rd(prc_pkg::OFF_MULT);
    chk(d, 32'h100);
    wr(ST, 32'hc4);
    blk(0, 0, 8'h41);
    wr(prc_pkg::OFF_CAPS, 0);
    wr(ST, 32'h22);
    blk(0, 0, 8'h41);
    rd(prc_pkg::OFF_ERR);
    chk(d, 32'h04);
    wr(prc_pkg::OFF_CAPS, 3);
    wr(SN, 32'h11);
    wr(prc_pkg::OFF_CYLL, 32'h22);
    wr(prc_pkg::OFF_CYLH, 32'h33);
    wr(prc_pkg::OFF_DEVH, 32'h04);
    for (int j = 0; j < 4; j++)
    begin
      unc <= j[1];
      wr(SC, 1);
      wr(ST, 32'h20 + j);
      blk(1, j[1], 8'h48);
      chk(mlba, 28'h4332211 + j);
    end
    unc <= 0;
    cr <= 1;
    wr(prc_pkg::OFF_MULT, 32'h102);
    wr(SC, 3);
    wr(ST, 32'hc4);
    blk(2, 0, 8'h4c);
    blk(1, 0, 8'h4c);
    unc <= 1;
    cr <= 0;
    wr(SC, 2);
    wr(ST, 32'h20);
    blk(1, 0, 8'h49);
    rd(ST);
    chk(d, 32'h41);
    rd(SN);
    chk(d, 32'h18);
    unc <= 0;
    wr(SC, 0);
    wr(ST, 32'h21);
    blk(1, 0, 8'h48);
    rd(SC);
    chk(d, 32'hff);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(prc_pkg::OFF_MULT);
    chk(d, 32'h100);
    rd(ST);
    chk(d, 32'h40);
    summarize();
  end
endmodule
